// File: pkg/alert_therm_consts.vh
// offsets, field positions, reset values and timing counts of the alert mask / thermal timer bank
`ifndef ALERT_THERM_CONSTS_VH
`define ALERT_THERM_CONSTS_VH
`define OFS_ALERT_MASK_SECOND   8'h75
`define OFS_LOW_BITS_VOLTAGES   8'h76
`define OFS_LOW_BITS_TEMPS_12V  8'h77
`define OFS_CONFIG_THIRD        8'h78
`define OFS_THERMAL_FLAG_STATUS 8'h79
`define RST_ALERT_MASK_SECOND   8'h00
`define RST_CONFIG_THIRD        8'h00
`define RST_THERMAL_FLAG_STATUS 8'h00
`define BIT_TWELVE_VOLT_MASK    0
`define BIT_OVERTEMP_MASK       1
`define BIT_FAN1_MASK           2
`define BIT_FAN4_OR_TIMER_MASK  5
`define BIT_DIODE_ONE_MASK      6
`define BIT_DIODE_TWO_MASK      7
`define BIT_ALERT_PIN_SEL       0
`define BIT_FLAG_MONITOR        1
`define BIT_FULL_SPEED_ON_FLAG  2
`define BIT_FAST_SPEED          3
`define BIT_CONT_SPEED_CH1      4
`define CLK_HZ                  25000000
`define TIMER_STEP_US           22760
`define TIMER_STEP_CYCLES       ((`TIMER_STEP_US * 25) )
`endif

// File: logic/step_divider.v
// free-running divider producing a one-cycle enable every step
`timescale 1ns/10ps
`default_nettype none
module step_divider #(
  parameter integer STEP_CYCLES = 569000
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // control
  input  wire        restart,
  output reg         step
);
  reg [31:0] count;

  // restart aligns the first step to the start of an assertion
  always @(posedge core_clk) begin
    if (!resetn || restart) begin
      count <= 32'h00000000;
      step  <= 1'b0;
    end else if (count == STEP_CYCLES - 1) begin
      count <= 32'h00000000;
      step  <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      step  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: logic/alert_mask_therm_timer_regs.v
// register bank: second alert mask, low-bit readings, third config, thermal-flag timer
// Function
// - mask bit 0 blocks the alert for 12 V out-of-limit events
// - mask bit 1 is read-only and blocks overtemperature flag alerts
// - mask bits 2..4 block fan 1..3 fault alerts
// - mask bit 5 blocks fan 4 fault, or timer event when fan4 input is flag
// - mask bits 6,7 block diode fault alerts on remote 1 and 2
// - second mask register resets to zero
// - voltages low-bit register packs 2.5 V, core, supply, 5 V low bits
// - temps low-bit register packs 12 V, remote 1, local, remote 2 low bits
// - reading a low-bit register freezes it and its high registers until read
// - config bit 0 turns fan drive two pin into the alert output
// - config bit 1 enables flag monitoring on the selected pin
// - config bit 2 drives all fans full speed while flag asserted
// - config bit 3 selects 250 ms speed measurement period
// - config bits 4..7 make speed channels 1..4 measure continuously
// - lock bit makes third config register read-only
// - status bit 0 sets on flag assertion; a read clears it only if the flag is no longer asserted
// - upper status bits read zero until assertion exceeds 45.52 ms
// - after 45.52 ms status becomes 8-bit count, 22.76 ms steps
// - flag pin select routes the 5 V pin as the thermal flag
`include "alert_therm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module alert_mask_therm_timer_regs #(
  parameter integer STEP_CYCLES = `TIMER_STEP_CYCLES
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // register access from the serial interface logic
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output wire        hit,
  // other configuration held elsewhere
  input  wire        config_lock,
  input  wire        flag_pin_select,
  input  wire        overtemp_mask_in,
  // 10-bit results, live
  input  wire [9:0]  res_2v5,
  input  wire [9:0]  res_core,
  input  wire [9:0]  res_supply,
  input  wire [9:0]  res_5v,
  input  wire [9:0]  res_12v,
  input  wire [9:0]  res_remote1,
  input  wire [9:0]  res_local,
  input  wire [9:0]  res_remote2,
  // high-byte register reads reported by the bank that holds them
  input  wire [7:0]  high_read,
  output reg  [7:0]  high_freeze,
  output reg  [79:0] frozen_res,
  // pins
  input  wire        fan4_speed_input,
  input  wire        five_volt_pin,
  // event sources
  input  wire        ev_12v,
  input  wire        ev_fan1,
  input  wire        ev_fan2,
  input  wire        ev_fan3,
  input  wire        ev_fan4,
  input  wire        ev_timer,
  input  wire        ev_diode1,
  input  wire        ev_diode2,
  // outputs to the rest of the chip
  output wire [7:0]  alert_sources,
  output wire        alert_on_fan_drive_two_pin,
  output wire        full_speed_all,
  output wire        fast_speed,
  output wire [3:0]  continuous_speed,
  output wire        flag_active
);
  reg  [7:0] alert_mask_second;
  reg  [7:0] config_third;
  reg  [7:0] elapsed_steps;
  reg        assert_seen_bit;
  reg        over_threshold;
  reg  [1:0] phase;
  reg  [1:0] next_phase;
  reg  [1:0] sync_five;
  reg  [1:0] sync_fan4;
  reg        flag_q;
  reg  [79:0] live_snapshot;
  wire [79:0] live_res;
  wire       sel_mask;
  wire       sel_volt;
  wire       sel_temp;
  wire       sel_cfg;
  wire       sel_stat;
  wire       raw_flag;
  wire       step;
  wire       flag_rise;
  wire [7:0] events;
  wire [7:0] volt_low;
  wire [7:0] temp_low;
  wire [7:0] status_view;
  wire [6:0] assert_time_count;
  wire       count_step;
  wire       long_step;

  // assertion phases: idle, first step pending, second step pending, long
  localparam [1:0] PH_IDLE   = 2'b00;
  localparam [1:0] PH_FIRST  = 2'b01;
  localparam [1:0] PH_SECOND = 2'b10;
  localparam [1:0] PH_LONG   = 2'b11;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign sel_mask = (reg_addr == `OFS_ALERT_MASK_SECOND);
  assign sel_volt = (reg_addr == `OFS_LOW_BITS_VOLTAGES);
  assign sel_temp = (reg_addr == `OFS_LOW_BITS_TEMPS_12V);
  assign sel_cfg  = (reg_addr == `OFS_CONFIG_THIRD);
  assign sel_stat = (reg_addr == `OFS_THERMAL_FLAG_STATUS);
  assign hit      = sel_mask | sel_volt | sel_temp | sel_cfg | sel_stat;

  // ------------------------------------------------------------
  // flag input synchronisers
  // ------------------------------------------------------------
  // both candidate pins are synchronised so a change of select never glitches
  always @(posedge core_clk) begin
    if (!resetn) begin
      sync_five <= 2'b11;
      sync_fan4 <= 2'b11;
      flag_q    <= 1'b0;
    end else begin
      sync_five <= {sync_five[0], five_volt_pin};
      sync_fan4 <= {sync_fan4[0], fan4_speed_input};
      flag_q    <= raw_flag;
    end
  end

  // flag is active low on the pin
  // monitoring off forces it inactive, so a pin used as a plain input
  // never starts the timer or raises an alert
  assign raw_flag    = config_third[`BIT_FLAG_MONITOR] &
                       ~(flag_pin_select ? sync_five[1] : sync_fan4[1]);
  assign flag_rise   = raw_flag & ~flag_q;
  assign flag_active = raw_flag;

  // ------------------------------------------------------------
  // alert mask register
  // ------------------------------------------------------------
  // overtemp bit is fed from outside since software cannot write it
  always @(posedge core_clk) begin
    if (!resetn) begin
      alert_mask_second <= `RST_ALERT_MASK_SECOND;
    end else if (reg_wr && sel_mask) begin
      alert_mask_second <= reg_wdata;
    end
  end

  // events gated by the mask; bit 5 follows the pin use of the fan4 input
  assign events = {ev_diode2, ev_diode1,
                   (config_third[`BIT_FLAG_MONITOR] && !flag_pin_select) ? ev_timer : ev_fan4,
                   ev_fan3, ev_fan2, ev_fan1, raw_flag, ev_12v};
  assign alert_sources[`BIT_TWELVE_VOLT_MASK] =
    events[0] & ~alert_mask_second[`BIT_TWELVE_VOLT_MASK];
  assign alert_sources[`BIT_OVERTEMP_MASK] = events[1] & ~overtemp_mask_in;
  assign alert_sources[4:2] = events[4:2] & ~alert_mask_second[4:2];
  assign alert_sources[`BIT_FAN4_OR_TIMER_MASK] =
    events[5] & ~alert_mask_second[`BIT_FAN4_OR_TIMER_MASK];
  assign alert_sources[7:6] = events[7:6] & ~alert_mask_second[7:6];

  // ------------------------------------------------------------
  // third configuration register
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!resetn) begin
      config_third <= `RST_CONFIG_THIRD;
    end else if (reg_wr && sel_cfg && !config_lock) begin
      config_third <= reg_wdata;
    end
  end

  assign alert_on_fan_drive_two_pin = config_third[`BIT_ALERT_PIN_SEL];
  assign full_speed_all   = config_third[`BIT_FULL_SPEED_ON_FLAG] & raw_flag;
  assign fast_speed       = config_third[`BIT_FAST_SPEED];
  assign continuous_speed = config_third[7:4];

  // ------------------------------------------------------------
  // low-bit freeze
  // ------------------------------------------------------------
  assign live_res = {res_remote2, res_local, res_remote1, res_12v,
                     res_5v, res_supply, res_core, res_2v5};

  // a low-bit read freezes its four channels until each high byte is read;
  // high_freeze bit n stays up until high_read[n]
  // limitation: a second low-bit read while frozen keeps the first capture,
  // so low and high halves still come from the same conversion
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_freeze
      always @(posedge core_clk) begin
        if (!resetn) begin
          high_freeze[g]            <= 1'b0;
          frozen_res[g*10 +: 10]    <= 10'h000;
        end else if (reg_rd && ((g < 4) ? sel_volt : sel_temp)) begin
          high_freeze[g]            <= 1'b1;
          frozen_res[g*10 +: 10]    <= high_freeze[g] ? frozen_res[g*10 +: 10]
                                                      : live_res[g*10 +: 10];
        end else if (high_read[g]) begin
          high_freeze[g]            <= 1'b0;
        end else if (!high_freeze[g]) begin
          frozen_res[g*10 +: 10]    <= live_res[g*10 +: 10];
        end
      end
    end
  endgenerate

  // low bits returned; a frozen channel returns its captured value
  always @* begin
    live_snapshot = live_res;
  end
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_low
      assign volt_low[g*2 +: 2] = high_freeze[g] ? frozen_res[g*10 +: 2]
                                                 : live_snapshot[g*10 +: 2];
      assign temp_low[g*2 +: 2] = high_freeze[g+4] ? frozen_res[(g+4)*10 +: 2]
                                                   : live_snapshot[(g+4)*10 +: 2];
    end
  endgenerate

  // ------------------------------------------------------------
  // thermal-flag timer
  // ------------------------------------------------------------
  // one step pulse every 22.76 ms; restarting on a rising flag puts the
  // first step a full period after the assertion began
  step_divider #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_step (
    .core_clk (core_clk),
    .resetn   (resetn),
    .restart  (flag_rise),
    .step     (step)
  );

  // ------------------------------------------------------------
  // assertion phase
  // ------------------------------------------------------------
  // the count view opens only when one assertion outlasts two steps
  // (45.52 ms); short pulses that add up never open it on their own
  always @(posedge core_clk) begin
    if (!resetn) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // a released flag always returns to idle, whatever step is pending
  always @* begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (flag_rise) begin
          next_phase = PH_FIRST;
        end
      end
      PH_FIRST: begin
        if (!raw_flag) begin
          next_phase = PH_IDLE;
        end else if (step) begin
          next_phase = PH_SECOND;
        end
      end
      PH_SECOND: begin
        if (!raw_flag) begin
          next_phase = PH_IDLE;
        end else if (step) begin
          next_phase = PH_LONG;
        end
      end
      PH_LONG: begin
        if (!raw_flag) begin
          next_phase = PH_IDLE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // status and elapsed-time count
  // ------------------------------------------------------------
  // steps are counted only while the flag is asserted
  assign count_step = raw_flag & step;
  // a step that takes one assertion past two steps opens the count view
  assign long_step  = count_step & ((phase == PH_SECOND) | (phase == PH_LONG));

  // the count accumulates over assertions until read; a read clears it but
  // an event in the same cycle still lands, so no assertion is ever lost
  always @(posedge core_clk) begin
    if (!resetn) begin
      assert_seen_bit <= 1'b0;
      elapsed_steps   <= 8'h00;
      over_threshold  <= 1'b0;
    end else if (reg_rd && sel_stat) begin
      assert_seen_bit <= raw_flag;
      elapsed_steps   <= {7'h00, count_step};
      over_threshold  <= long_step;
    end else begin
      if (flag_rise) begin
        assert_seen_bit <= 1'b1;
      end
      // saturate: a flag held past the range keeps reading all ones
      if (count_step && (elapsed_steps != 8'hFF)) begin
        elapsed_steps <= elapsed_steps + 8'h01;
      end
      if (long_step) begin
        over_threshold <= 1'b1;
      end
    end
  end

  // below threshold only the seen bit is visible; past it bit 0 is the
  // low bit of the elapsed count
  assign assert_time_count = elapsed_steps[7:1];
  assign status_view = over_threshold ? {assert_time_count, elapsed_steps[0]}
                                      : {7'h00, assert_seen_bit};

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // registered read data; unmapped addresses return zero so the serial
  // side can merge several banks without a decode of its own
  always @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (1'b1)
        sel_mask: reg_rdata <= {alert_mask_second[7:2], overtemp_mask_in,
                                alert_mask_second[0]};
        sel_volt: reg_rdata <= volt_low;
        sel_temp: reg_rdata <= temp_low;
        sel_cfg:  reg_rdata <= config_third;
        sel_stat: reg_rdata <= status_view;
        default:  reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verif/regs_props.sv
// concurrent checks on the ports of the alert mask / thermal timer bank
`include "alert_therm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module regs_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // side inputs
  input wire logic       config_lock,
  input wire logic       overtemp_mask_in,
  input wire logic       ev_12v,
  input wire logic       ev_fan1,
  input wire logic       ev_fan2,
  input wire logic       ev_fan3,
  input wire logic       ev_diode1,
  input wire logic       ev_diode2,
  // outputs under watch
  input wire logic [7:0] high_freeze,
  input wire logic [7:0] alert_sources,
  input wire logic       alert_on_fan_drive_two_pin,
  input wire logic       full_speed_all,
  input wire logic       fast_speed,
  input wire logic [3:0] continuous_speed,
  input wire logic       flag_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // decoded accesses
  // ----------------------------------------
  wire cfg_wr = reg_wr && reg_addr == `OFS_CONFIG_THIRD;
  wire msk_wr = reg_wr && reg_addr == `OFS_ALERT_MASK_SECOND;
  sequence s_read_volts; reg_rd && reg_addr == `OFS_LOW_BITS_VOLTAGES; endsequence
  sequence s_read_temps; reg_rd && reg_addr == `OFS_LOW_BITS_TEMPS_12V; endsequence
  // config outputs follow an unlocked write on the next edge
  a_cfg_write_lands: assert property (cfg_wr && !config_lock |=>
    {continuous_speed, fast_speed} == $past(reg_wdata[7:3])
    && alert_on_fan_drive_two_pin == $past(reg_wdata[0]))
    else $error("config write not applied");
  a_cfg_lock_holds: assert property (cfg_wr && config_lock |=>
    $stable({continuous_speed, fast_speed, alert_on_fan_drive_two_pin}))
    else $error("locked config changed");
  a_full_speed_on_flag_needs_flag: assert property (full_speed_all |-> flag_active)
    else $error("full speed without flag");
  a_full_speed_on_flag_follows_flag: assert property (cfg_wr && !config_lock |=>
    full_speed_all == ($past(reg_wdata[2]) && flag_active))
    else $error("full speed does not follow config bit 2");
  a_mask_twelve_volt: assert property (msk_wr |=>
    alert_sources[0] == (ev_12v & ~$past(reg_wdata[0])))
    else $error("12 V alert mask wrong");
  a_mask_fan_faults: assert property (msk_wr |=>
    alert_sources[4:2] == ({ev_fan3, ev_fan2, ev_fan1} & ~$past(reg_wdata[4:2])))
    else $error("fan alert mask wrong");
  a_mask_diode_faults: assert property (msk_wr |=>
    alert_sources[7:6] == ({ev_diode2, ev_diode1} & ~$past(reg_wdata[7:6])))
    else $error("diode alert mask wrong");
  a_freeze_volts: assert property (s_read_volts |=> high_freeze[3:0] == 4'hF)
    else $error("voltage channels not frozen");
  a_freeze_temps: assert property (s_read_temps |=> high_freeze[7:4] == 4'hF)
    else $error("temperature channels not frozen");
  a_overtemp_readonly: assert property (reg_rd && reg_addr == `OFS_ALERT_MASK_SECOND |=>
    reg_rdata[1] == $past(overtemp_mask_in))
    else $error("overtemp mask bit not from its source");
endmodule
bind alert_mask_therm_timer_regs regs_props props (.*);
`default_nettype wire

// File: verif/reg_host_model.sv
// host model issuing single-cycle read and write strobes to the bank
`timescale 1ns/10ps
`default_nettype none
module reg_host_model (
  input  wire logic       core_clk,
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic       reg_wr = 1'b0,
  output var  logic       reg_rd = 1'b0,
  output var  logic [7:0] reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata
);
  // strobes change only at falling edges, so the taking edge sees them settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // stale data never mimics a valid write
  endtask
  // read data is registered at the taking edge and sampled half a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the alert mask / thermal timer bank
`include "alert_therm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam integer step = 10; // short timer step keeps the run brief
  localparam [7:0] ms = `OFS_ALERT_MASK_SECOND;
  localparam [7:0] cf = `OFS_CONFIG_THIRD;
  localparam [7:0] st = `OFS_THERMAL_FLAG_STATUS;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, high_freeze, alert_sources;
  wire reg_wr, reg_rd, hit, alert_on_fan_drive_two_pin, full_speed_all, fast_speed, flag_active;
  wire [3:0] continuous_speed;
  wire [79:0] frozen_res;
  logic config_lock = 0, flag_pin_select = 0, overtemp_mask_in = 0;
  logic fan4_speed_input = 1, five_volt_pin = 1, ev_timer = 0;
  logic ev_12v = 0, ev_fan1 = 0, ev_fan2 = 0, ev_fan3 = 0, ev_fan4 = 0;
  logic ev_diode1 = 0, ev_diode2 = 0;
  logic [9:0] res_2v5 = 0, res_core = 0, res_supply = 0, res_5v = 0;
  logic [9:0] res_12v = 0, res_remote1 = 0, res_local = 0, res_remote2 = 0;
  logic [7:0] high_read = 8'h00;
  logic [7:0] rv;
  int bad_count = 0;
  int check_count = 0;
  int wt[3] = '{15, 55, 3000};
  logic [7:0] ex[3] = '{8'h01, 8'h05, 8'hFF};
  alert_mask_therm_timer_regs #(.STEP_CYCLES(step)) dut (.*);
  reg_host_model host (.*);
  always #20 core_clk = ~core_clk;
  // ----------------------------------------
  // compare and report helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    check($sformatf("register %h", a), exp, rv);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hung run counts as a failure
  initial begin
    #800000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    cyc(20);
    resetn = 1'b1;
    rchk(ms, 8'h00);
    rchk(cf, 8'h00);
    rchk(st, 8'h00);
    $display("test reset values done");
    {ev_diode2, ev_diode1, ev_fan4, ev_fan3, ev_fan2, ev_fan1, ev_12v} = 7'h7F;
    host.wr(8'h74, 8'hFF); // unmapped neighbour must not alias
    check("hit unmapped", 8'h00, {7'h00, hit});
    rchk(ms, 8'h00);
    check("hit mapped", 8'h01, {7'h00, hit});
    host.wr(ms, 8'hFF);
    rchk(ms, 8'hFD);
    check("sources masked", 8'h00, alert_sources & 8'hFD);
    overtemp_mask_in = 1'b1;
    rchk(ms, 8'hFF);
    host.wr(ms, 8'h5A);
    check("sources partial", 8'hA5, alert_sources & 8'hFD);
    host.wr(ms, 8'h00);
    check("sources open", 8'hFD, alert_sources & 8'hFD);
    $display("test alert masks done");
    {res_5v, res_supply, res_core, res_2v5} = {10'h000, 10'h003, 10'h002, 10'h001};
    {res_remote2, res_local, res_remote1, res_12v} = {10'h002, 10'h001, 10'h000, 10'h003};
    rchk(`OFS_LOW_BITS_VOLTAGES, 8'h39);
    check("freeze volts", 8'h0F, high_freeze);
    rchk(`OFS_LOW_BITS_TEMPS_12V, 8'h93);
    check("freeze all", 8'hFF, high_freeze);
    {res_5v, res_supply, res_core, res_2v5} = {10'h003, 10'h000, 10'h001, 10'h002};
    {res_remote2, res_local, res_remote1, res_12v} = {10'h001, 10'h002, 10'h003, 10'h000};
    rchk(`OFS_LOW_BITS_VOLTAGES, 8'h39);
    rchk(`OFS_LOW_BITS_TEMPS_12V, 8'h93);
    check("frozen 2v5", 8'h01, frozen_res[7:0]);
    high_read = 8'hFF;
    cyc(1);
    high_read = 8'h00;
    check("freeze released", 8'h00, high_freeze);
    rchk(`OFS_LOW_BITS_VOLTAGES, 8'hC6);
    high_read = 8'hFF;
    cyc(1);
    high_read = 8'h00;
    rchk(`OFS_LOW_BITS_TEMPS_12V, 8'h6C);
    $display("test low bits done");
    host.wr(cf, 8'hF9);
    rchk(cf, 8'hF9);
    check("cfg outputs", 8'hF9, {continuous_speed, fast_speed, 2'b00, alert_on_fan_drive_two_pin});
    cyc(4);
    fan4_speed_input = 1'b0;
    cyc(4);
    check("flag while off", 8'h00, {7'h00, flag_active});
    config_lock = 1'b1;
    host.wr(cf, 8'h06);
    rchk(cf, 8'hF9);
    config_lock = 1'b0;
    host.wr(cf, 8'h06);
    flag_pin_select = 1'b1;
    cyc(4);
    check("flag on unselected pin", 8'h00, {7'h00, flag_active});
    flag_pin_select = 1'b0;
    ev_fan4 = 1'b0;
    ev_timer = 1'b1;
    cyc(4);
    check("flag on fan4 pin", 8'h03, {6'h00, full_speed_all, flag_active});
    check("timer source", 8'h20, alert_sources & 8'h20);
    check("overtemp masked", 8'h00, alert_sources & 8'h02);
    overtemp_mask_in = 1'b0;
    cyc(1);
    check("overtemp open", 8'h02, alert_sources & 8'h02);
    overtemp_mask_in = 1'b1;
    fan4_speed_input = 1'b1;
    flag_pin_select = 1'b1;
    $display("test config done");
    // each pass starts from a cleared status and a fresh assertion
    for (int i = 0; i < 3; i++) begin
      five_volt_pin = 1'b1;
      cyc(4);
      host.rd(st, rv);
      five_volt_pin = 1'b0;
      cyc(wt[i]);
      rchk(st, ex[i]);
    end
    five_volt_pin = 1'b1;
    cyc(4);
    rchk(st, 8'h01);
    rchk(st, 8'h00);
    $display("test thermal timer done");
    // a second reset in mid-run must restore every default
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    rchk(ms, 8'h02);
    rchk(cf, 8'h00);
    rchk(st, 8'h00);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
